// *** bus_control.sv ***
/*
  Processor end of the system bus: DMA grant arbitration, daisy-chained
  interrupt acknowledge, init generation and power sequencing.
  Assumes front-panel and supply inputs are asynchronous pins; bus lines
  return from logic on the same clock.
*/
`timescale 1ns/1ps
module bus_control #(
  parameter int unsigned POK_CYCLES = sysbus_pkg::POK_DELAY_CYCLES,
  parameter int unsigned DCOK_CYCLES = sysbus_pkg::DCOK_HOLD_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  sysbus_if.cpu bus,
  input wire logic cpu_cycle_active,
  input wire logic irq_enable,
  input wire logic soft_clear,
  input wire logic panel_reset,
  input wire logic supply_power_good,
  input wire logic halt_req,
  output logic cpu_stall,
  output logic cpu_run,
  output logic irq_taken,
  output logic [sysbus_pkg::VECTOR_WIDTH-1:0] irq_vector,
  output logic power_fail_irq
);
  import sysbus_pkg::*;

  // A count of zero would underflow the end-of-wait compare.
  if (POK_CYCLES < 1 || DCOK_CYCLES < 1)
  begin : g_delay_check
    $error("bus_control: delay counts must be at least one cycle");
  end

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic [1:0] panel_sync;
  logic [1:0] pg_sync;
  logic [1:0] halt_sync;
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      panel_sync <= 2'h0;
      pg_sync <= 2'h0;
      halt_sync <= 2'h0;
    end
    else
    begin
      panel_sync <= {panel_sync[0], panel_reset};
      pg_sync <= {pg_sync[0], supply_power_good};
      halt_sync <= {halt_sync[0], halt_req};
    end
  end
  logic panel_s;
  logic pg_s;
  logic halt_s;
  assign panel_s = panel_sync[1];
  assign pg_s = pg_sync[1];
  assign halt_s = halt_sync[1];

  // ****************************************************
  // Power sequencer
  // ****************************************************
  power_state_t pstate;
  power_state_t next_pstate;
  logic [31:0] pcount;
  logic [31:0] next_pcount;
  logic pfail;
  logic next_pfail;
  always_comb
  begin
    next_pstate = pstate;
    next_pcount = pcount;
    next_pfail = 1'b0;
    unique case (pstate)
      pwr_off:
      begin
        if (pg_s)
        begin
          next_pstate = pwr_dc_wait;
          next_pcount = 32'h0;
        end
      end
      pwr_dc_wait:
      begin
        if (!pg_s)
        begin
          next_pstate = pwr_fall;
          next_pcount = 32'h0;
        end
        else if (pcount >= 32'(POK_CYCLES - 1))
        begin
          next_pstate = pwr_on;
        end
        else
        begin
          next_pcount = pcount + 32'h1;
        end
      end
      pwr_on:
      begin
        if (!pg_s)
        begin
          next_pstate = pwr_fall;
          next_pcount = 32'h0;
          next_pfail = 1'b1;
        end
      end
      pwr_fall:
      begin
        if (pcount >= 32'(DCOK_CYCLES - 1))
        begin
          next_pstate = pwr_off;
        end
        else
        begin
          next_pcount = pcount + 32'h1;
        end
      end
    endcase
  end
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      pstate <= pwr_off;
      pcount <= 32'h0;
      pfail <= 1'b0;
    end
    else
    begin
      pstate <= next_pstate;
      pcount <= next_pcount;
      pfail <= next_pfail;
    end
  end
  // Init is asserted when the bus line goes low; high power_ok with no panel reset and no halt means running, even while soft_clear holds init.
  logic powered;
  // The power-down hold keeps dc_ok up and init released until the count runs out.
  assign powered = (pstate != pwr_off);
  assign bus.dc_ok = powered;
  assign bus.power_ok = (pstate == pwr_on);
  assign bus.bus_init = !powered || panel_s || soft_clear;
  assign bus.refresh = 1'b0;
  assign cpu_run = (pstate == pwr_on) && !panel_s && !halt_s;
  assign cpu_stall = halt_s;
  assign power_fail_irq = pfail;

  // ****************************************************
  // Arbiter
  // ****************************************************
  arb_state_t astate;
  arb_state_t next_astate;
  logic irq_latched;
  logic next_irq_latched;
  logic next_irq_taken;
  logic [VECTOR_WIDTH-1:0] next_irq_vector;
  always_comb
  begin
    next_astate = astate;
    next_irq_latched = irq_latched || bus.irq_req;
    next_irq_taken = 1'b0;
    next_irq_vector = irq_vector;
    if (pfail)
    begin
      next_irq_vector = POWER_FAIL_VECTOR;
    end
    unique case (astate)
      arb_idle:
      begin
        // Halt blocks interrupt entry only; DMA stays open. No in-service mask, so nesting is unlimited.
        if (bus.dma_req && !cpu_cycle_active)
        begin
          next_astate = arb_dma_grant;
        end
        else if (irq_latched && irq_enable && !halt_s && !cpu_cycle_active)
        begin
          next_astate = arb_irq_ack;
        end
      end
      arb_dma_grant:
      begin
        if (bus.slave_ack)
        begin
          next_astate = arb_dma_owned;
        end
        else if (!bus.dma_req)
        begin
          next_astate = arb_idle;
        end
      end
      arb_dma_owned:
      begin
        if (!bus.slave_ack)
        begin
          next_astate = arb_idle;
        end
      end
      arb_irq_ack:
      begin
        if (bus.vector_valid)
        begin
          next_astate = arb_idle;
          next_irq_vector = bus.vector;
          next_irq_taken = 1'b1;
          next_irq_latched = bus.irq_req;
        end
        else if (!bus.irq_req && !irq_latched)
        begin
          next_astate = arb_idle;
        end
      end
      default:
      begin
        next_astate = arb_idle;
      end
    endcase
    if (bus.bus_init)
    begin
      next_astate = arb_idle;
      next_irq_latched = 1'b0;
    end
  end
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      astate <= arb_idle;
      irq_latched <= 1'b0;
      irq_taken <= 1'b0;
      irq_vector <= '0;
    end
    else
    begin
      astate <= next_astate;
      irq_latched <= next_irq_latched;
      irq_taken <= next_irq_taken;
      irq_vector <= next_irq_vector;
    end
  end
  assign bus.dma_grant_out = (astate == arb_dma_grant);
  assign bus.irq_ack_out = (astate == arb_irq_ack);
endmodule : bus_control

// *** bus_slot.sv ***
/*
  Peripheral end: one slot on the grant and acknowledge daisy chains, with a
  simple DMA master request and a hard-wired interrupt vector.
  Assumes chain inputs come from logic on the same clock.
*/
`timescale 1ns/1ps
module bus_slot #(
  parameter logic [sysbus_pkg::VECTOR_WIDTH-1:0] SLOT_VECTOR = 16'h0040
) (
  input wire logic clock,
  input wire logic nrst,
  sysbus_if.periph bus,
  input wire logic want_dma,
  input wire logic dma_done,
  input wire logic want_irq,
  output logic dma_master,
  output logic irq_served
);
  import sysbus_pkg::*;

  logic dma_pend;
  logic next_dma_pend;
  logic irq_pend;
  logic next_irq_pend;
  logic next_dma_master;
  logic next_irq_served;
  logic [VECTOR_WIDTH-1:0] vec_q;
  logic [VECTOR_WIDTH-1:0] next_vec_q;
  logic vec_v;
  logic next_vec_v;

  always_comb
  begin
    next_dma_pend = dma_pend;
    next_irq_pend = irq_pend;
    next_dma_master = dma_master;
    next_irq_served = 1'b0;
    next_vec_v = 1'b0;
    next_vec_q = vec_q;
    if (want_dma)
    begin
      next_dma_pend = 1'b1;
    end
    if (want_irq)
    begin
      next_irq_pend = 1'b1;
    end
    if (dma_pend && bus.dma_grant_in && !dma_master)
    begin
      next_dma_master = 1'b1;
    end
    if (dma_master && dma_done)
    begin
      next_dma_master = 1'b0;
      next_dma_pend = want_dma;
    end
    if (irq_pend && bus.irq_ack_in && !vec_v)
    begin
      next_vec_v = 1'b1;
      next_vec_q = SLOT_VECTOR;
      next_irq_pend = want_irq;
      next_irq_served = 1'b1;
    end
    if (bus.bus_init)
    begin
      next_dma_pend = 1'b0;
      next_irq_pend = 1'b0;
      next_dma_master = 1'b0;
      next_vec_v = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      dma_pend <= 1'b0;
      irq_pend <= 1'b0;
      dma_master <= 1'b0;
      irq_served <= 1'b0;
      vec_v <= 1'b0;
      vec_q <= '0;
    end
    else
    begin
      dma_pend <= next_dma_pend;
      irq_pend <= next_irq_pend;
      dma_master <= next_dma_master;
      irq_served <= next_irq_served;
      vec_v <= next_vec_v;
      vec_q <= next_vec_q;
    end
  end

  assign bus.dma_req = dma_pend && !dma_master;
  assign bus.slave_ack = dma_master;
  assign bus.dma_grant_out = bus.dma_grant_in && !dma_pend;
  assign bus.irq_req = irq_pend;
  assign bus.irq_ack_out = bus.irq_ack_in && !irq_pend;
  assign bus.vector_valid = vec_v;
  assign bus.vector = vec_q;
endmodule : bus_slot

// *** sysbus_if.sv ***
/*
  Backplane control lines between processor end and one peripheral slot.
  Active-low bus lines are carried as active-high asserted levels; the
  testbench wires the daisy chains between the processor end and the slot.
*/
`timescale 1ns/1ps
interface sysbus_if;
  logic dma_req;
  logic dma_grant_in;
  logic dma_grant_out;
  logic slave_ack;
  logic irq_req;
  logic irq_ack_in;
  logic irq_ack_out;
  logic vector_valid;
  logic [sysbus_pkg::VECTOR_WIDTH-1:0] vector;
  logic bus_init;
  logic dc_ok;
  logic power_ok;
  logic refresh;

  modport cpu (
    input dma_req,
    output dma_grant_out,
    input slave_ack,
    input irq_req,
    output irq_ack_out,
    input vector_valid,
    input vector,
    output bus_init,
    output dc_ok,
    output power_ok,
    output refresh
  );

  modport periph (
    output dma_req,
    input dma_grant_in,
    output dma_grant_out,
    output slave_ack,
    output irq_req,
    input irq_ack_in,
    output irq_ack_out,
    output vector_valid,
    output vector,
    input bus_init
  );
endinterface : sysbus_if

// *** sysbus_pkg.sv ***
/*
  Shared constants and types for the system bus control pair: the processor-side
  arbiter and the peripheral-side daisy-chain slot. Assumes a 200 MHz clock.
*/
package sysbus_pkg;

  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned POK_DELAY_MS = 70;
  localparam int unsigned DCOK_HOLD_MS = 3;
  localparam int unsigned POK_DELAY_CYCLES = POK_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned DCOK_HOLD_CYCLES = DCOK_HOLD_MS * 1000 * CLK_MHZ;
  localparam logic [15:0] POWER_FAIL_VECTOR = 16'h0006;
  localparam int unsigned VECTOR_WIDTH = 16;

  typedef enum logic [2:0] {
    pwr_off,
    pwr_dc_wait,
    pwr_on,
    pwr_fall
  } power_state_t;

  typedef enum logic [2:0] {
    arb_idle,
    arb_dma_grant,
    arb_dma_owned,
    arb_irq_ack,
    arb_irq_vector
  } arb_state_t;

endpackage : sysbus_pkg

// *** sysbus_sva.sv ***
/*
  Concurrent checks on the processor-side bus lines of the control pair.
  Assumes the testbench instantiates it beside the interface on one clock.
*/
`timescale 1ns/1ps
module sysbus_sva (
  input wire logic clock,
  input wire logic nrst,
  input wire logic dma_req,
  input wire logic dma_grant_out,
  input wire logic slave_ack,
  input wire logic irq_req,
  input wire logic irq_ack_out,
  input wire logic vector_valid,
  input wire logic bus_init,
  input wire logic dc_ok,
  input wire logic power_ok,
  input wire logic refresh
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // ****************************************
  // Line relations
  // ****************************************
  a_refresh_idle: assert property (!refresh)
    else $error("refresh line driven");
  a_grant_ack_apart: assert property (!(dma_grant_out && irq_ack_out))
    else $error("grant and acknowledge together");
  a_grant_drops_ack: assert property (dma_grant_out && slave_ack |=> !dma_grant_out)
    else $error("grant kept after slave ack");
  a_grant_init_free: assert property ($rose(dma_grant_out) |-> !$past(bus_init))
    else $error("grant offered during init");
  a_ack_stands: assert property (irq_ack_out && !vector_valid |=> irq_ack_out)
    else $error("acknowledge dropped early");
  a_vector_after_ack: assert property ($rose(vector_valid) |-> $past(irq_ack_out))
    else $error("vector without acknowledge");
  a_pok_needs_dcok: assert property (power_ok |-> dc_ok)
    else $error("power ok without dc ok");
  a_pok_waits: assert property ($rose(dc_ok) |-> !power_ok [*8])
    else $error("power ok too early");
  a_dcok_holds: assert property ($fell(power_ok) |-> dc_ok [*4])
    else $error("dc ok dropped too early");
  c_grant: cover property (dma_grant_out && slave_ack);
  c_ack: cover property (irq_ack_out && vector_valid);
  c_pok_up: cover property ($rose(power_ok));
  c_pok_down: cover property ($fell(power_ok));
endmodule : sysbus_sva

// *** system_bus_control_tb.sv ***
/*
  Self-checking bench for the processor end facing one peripheral slot.
  Assumes shortened power counts; the two ends meet through two interface copies.
*/
`timescale 1ns/1ps
module system_bus_control_tb;
  import sysbus_pkg::*;
  localparam int unsigned POK = 20;
  localparam logic [15:0] VEC = 16'h00C4;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0, ien = 1'b0, sclr = 1'b0, panel = 1'b0, pgood = 1'b0, halt = 1'b0;
  logic want_dma = 1'b0, dma_done = 1'b0, want_irq = 1'b0;
  logic stall, run, taken, pfail, master, served;
  logic [15:0] vec;
  int bad_count = 0;
  int samples_checked = 0;
  sysbus_if c_if();
  sysbus_if s_if();
  // Each end drives its own copy; the chains are stitched here.
  assign s_if.dma_grant_in = c_if.dma_grant_out;
  assign s_if.irq_ack_in = c_if.irq_ack_out;
  assign s_if.bus_init = c_if.bus_init;
  assign c_if.dma_req = s_if.dma_req;
  assign c_if.slave_ack = s_if.slave_ack;
  assign c_if.irq_req = s_if.irq_req;
  assign c_if.vector_valid = s_if.vector_valid;
  assign c_if.vector = s_if.vector;
  bus_control #(.POK_CYCLES(POK), .DCOK_CYCLES(5)) u_bus_control (.clock(clock), .nrst(nrst), .bus(c_if),
    .cpu_cycle_active(cyc), .irq_enable(ien), .soft_clear(sclr), .panel_reset(panel),
    .supply_power_good(pgood), .halt_req(halt), .cpu_stall(stall), .cpu_run(run),
    .irq_taken(taken), .irq_vector(vec), .power_fail_irq(pfail));
  bus_slot #(.SLOT_VECTOR(VEC)) u_bus_slot (.clock(clock), .nrst(nrst), .bus(s_if), .want_dma(want_dma),
    .dma_done(dma_done), .want_irq(want_irq), .dma_master(master), .irq_served(served));
  sysbus_sva u_sysbus_sva (.clock(clock), .nrst(nrst), .dma_req(c_if.dma_req),
    .dma_grant_out(c_if.dma_grant_out), .slave_ack(c_if.slave_ack), .irq_req(c_if.irq_req),
    .irq_ack_out(c_if.irq_ack_out), .vector_valid(c_if.vector_valid), .bus_init(c_if.bus_init),
    .dc_ok(c_if.dc_ok), .power_ok(c_if.power_ok), .refresh(c_if.refresh));
  initial
  begin
    forever #2.5 clock = ~clock;
  end
  task tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  // Waits at falling edges so that pulses one cycle long are seen settled.
  task wait_for(input int which);
    int i;
    i = 0;
    while (i < 40 && !(which == 0 ? master === 1'b1 : which == 1 ? taken === 1'b1 : c_if.irq_ack_out === 1'b1))
    begin
      tick(1);
      i++;
    end
  endtask : wait_for
  initial
  begin
    #20000;
    bad_count++;
    finish_test;
  end
  initial
  begin
    tick(5);
    nrst = 1'b1;
    tick(2);
    check(c_if.dc_ok, 1'b0);
    check(c_if.power_ok, 1'b0);
    pgood = 1'b1;
    tick(3);
    check(c_if.dc_ok, 1'b1);
    check(c_if.bus_init, 1'b0);
    tick(POK - 2);
    check(c_if.power_ok, 1'b0);
    tick(4);
    check(c_if.power_ok, 1'b1);
    $display("power-up test done");
    // ****************************************
    // DMA: refused inside a processor cycle, granted under halt
    // ****************************************
    cyc = 1'b1;
    halt = 1'b1;
    want_dma = 1'b1;
    tick(6);
    check(c_if.dma_grant_out, 1'b0);
    cyc = 1'b0;
    wait_for(0);
    check(master, 1'b1);
    check(stall, 1'b1);
    check(s_if.dma_grant_out, 1'b0);
    want_dma = 1'b0;
    dma_done = 1'b1;
    tick(1);
    dma_done = 1'b0;
    tick(3);
    check(master, 1'b0);
    $display("dma test done");
    // ****************************************
    // Interrupts: latched while disabled or halted, then nested twice
    // ****************************************
    want_irq = 1'b1;
    tick(1);
    want_irq = 1'b0;
    tick(6);
    check(c_if.irq_ack_out, 1'b0);
    ien = 1'b1;
    tick(6);
    check(c_if.irq_ack_out, 1'b0);
    halt = 1'b0;
    repeat (2)
    begin
      wait_for(2);
      check(s_if.irq_ack_out, 1'b0);
      tick(1);
      check(served, 1'b1);
      wait_for(1);
      check(taken, 1'b1);
      check(vec, VEC);
      want_irq = 1'b1;
      tick(1);
      want_irq = 1'b0;
    end
    $display("interrupt test done");
    sclr = 1'b1;
    tick(3);
    check(c_if.bus_init, 1'b1);
    check(run, 1'b1);
    sclr = 1'b0;
    panel = 1'b1;
    tick(12);
    check(c_if.bus_init, 1'b1);
    panel = 1'b0;
    tick(4);
    check(c_if.bus_init, 1'b0);
    $display("init test done");
    pgood = 1'b0;
    tick(3);
    check(pfail, 1'b1);
    check(c_if.power_ok, 1'b0);
    tick(2);
    check(vec, POWER_FAIL_VECTOR);
    check(c_if.dc_ok, 1'b1);
    check(c_if.bus_init, 1'b0);
    tick(6);
    check(c_if.dc_ok, 1'b0);
    check(c_if.bus_init, 1'b1);
    check(c_if.refresh, 1'b0);
    $display("power-down test done");
    finish_test;
  end
endmodule : system_bus_control_tb
